// file: design/spc_map.svh
// register offsets, field positions, reset values and timing counts of the sleep controller
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_OFF_CTRL      12'h000
`define SPC_OFF_CMD       12'h004
`define SPC_OFF_WAKE      12'h008
`define SPC_OFF_STAT      12'h00c
`define SPC_CTRL_ARM      0
`define SPC_CTRL_SEL_LO   1
`define SPC_CTRL_SEL_HI   3
`define SPC_CTRL_RADIO    4
`define SPC_CTRL_PINEN_LO 8
`define SPC_CTRL_PINEN_HI 15
`define SPC_CTRL_TMREN    16
`define SPC_CTRL_RST      32'h0000_0000
`define SPC_WAKE_RST      16'h0020
`define SPC_GATES_RST     6'h3f
`define SPC_CLK_MHZ       125
`define SPC_LF_HZ         32768
`define SPC_LF_DIV        (`SPC_CLK_MHZ * 1000000 / `SPC_LF_HZ)
`endif

// file: design/spc_pkg.sv
// types shared by the sleep controller
package spc_pkg;
  typedef enum logic [2:0] {
    SPC_IDLE    = 3'h0,
    SPC_ADCNR   = 3'h1,
    SPC_PWRDN   = 3'h2,
    SPC_PWRSAVE = 3'h3,
    SPC_STBY    = 3'h6,
    SPC_XSTBY   = 3'h7
  } spc_mode_t;

  typedef enum logic [2:0] {
    SPC_RUN   = 3'b001,
    SPC_SLEEP = 3'b010,
    SPC_WAKE  = 3'b100
  } spc_state_t;

  typedef struct packed {
    logic       cpuClkEn;
    logic       ioClkEn;
    logic       adcClkEn;
    logic       lfOscEn;
    logic       mainOscEn;
    logic       radioPwrEn;
  } spc_gate_t;
endpackage

// file: design/spc_sleep_ctrl.sv
// sleep and power-mode controller: arm bit, mode select, wake sources, reset pin
// assumes an AHB-Lite master, a cpu that pulses sleepInstr, async pins on wakePins/resetPin_n
//
// Function
// R1 - sleep only when arm bit is one and then the sleep instruction executes
// R2 - three-bit selector picks one of six sleep modes
// R3 - pin interrupts stay active in deep power-down and can wake
// R4 - timer on low-frequency oscillator wakes device at regular intervals
// R5 - idle with low-frequency timer is a per-variant option
// R6 - software can power off the radio and gate unused modules
// R7 - external logic should assert reset after slow ramp or power dip
// R8 - reset input active low with pull-up, undriven means deasserted
// R9 - sleep ignored when unarmed; enabled wake restores clocks and resumes
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_sleep_ctrl #(
  parameter bit LF_IDLE_OK = 1'b1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [11:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // cpu and wake sources
  input  wire logic             sleepInstr,
  input  wire logic [7:0]       wakePins,
  input  wire logic             resetPin_n,
  // power and clock gates
  output spc_pkg::spc_gate_t    gates,
  output logic                  sleeping,
  output logic                  wakeEvent,
  output logic                  extReset
);
  // bus and register state
  logic        wrPend_q, wrPend_d;
  logic [11:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [15:0] wakeIv_q, wakeIv_d;
  logic [7:0]  wakeSrc_q, wakeSrc_d;
  logic        tmrWake_q, tmrWake_d;
  // pin synchronisers: three stages, change counts when stages 2 and 3 agree
  logic [7:0]  pinS1_q, pinS2_q, pinS3_q, pinF_q, pinF_d;
  logic        rstS1_q, rstS2_q, rstS3_q, rstF_q, rstF_d;
  // sleep fsm and low-frequency timer
  spc_pkg::spc_state_t st_q, st_d;
  spc_pkg::spc_mode_t  mode_q, mode_d;
  logic [11:0] lfDiv_q, lfDiv_d;
  logic [15:0] tmr_q, tmr_d;
  spc_pkg::spc_gate_t gates_d;
  logic        wake_d, slp_d, xr_d;
  logic        armed, tmrHit, pinHit, lfTick, lfOn;
  logic [7:0]  pinEn;

  function automatic logic modeValid(input logic [2:0] m);
    modeValid = (m != 3'h4) && (m != 3'h5);
  endfunction

  // lf oscillator keeps running in modes that list it; deep power-down stops it
  function automatic logic lfRuns(input logic [2:0] m, input logic en);
    lfRuns = en && ((m == 3'(spc_pkg::SPC_IDLE) && LF_IDLE_OK) ||
                    m == 3'(spc_pkg::SPC_ADCNR) || m == 3'(spc_pkg::SPC_PWRSAVE) ||
                    m == 3'(spc_pkg::SPC_XSTBY));
  endfunction

  assign armed  = ctrl_q[`SPC_CTRL_ARM];
  assign pinEn  = ctrl_q[`SPC_CTRL_PINEN_HI:`SPC_CTRL_PINEN_LO];
  assign lfOn   = (st_q != spc_pkg::SPC_SLEEP) ? ctrl_q[`SPC_CTRL_TMREN]
                  : lfRuns(mode_q, ctrl_q[`SPC_CTRL_TMREN]); // R5
  assign lfTick = lfOn && (lfDiv_q == 12'(`SPC_LF_DIV - 1));
  assign tmrHit = lfTick && (tmr_q >= wakeIv_q) && (wakeIv_q != 16'h0000); // R4
  assign pinHit = |(pinF_q & pinEn); // R3

  always_comb begin
    pinF_d = pinF_q;
    for (int i = 0; i < 8; i++) begin
      if (pinS2_q[i] == pinS3_q[i]) begin
        pinF_d[i] = pinS3_q[i];
      end
    end
    rstF_d = (rstS2_q == rstS3_q) ? rstS3_q : rstF_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1_q <= 8'h00;
      pinS2_q <= 8'h00;
      pinS3_q <= 8'h00;
      pinF_q  <= 8'h00;
      rstS1_q <= 1'b1;
      rstS2_q <= 1'b1;
      rstS3_q <= 1'b1;
      rstF_q  <= 1'b1;
    end else begin
      pinS1_q <= wakePins;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q  <= pinF_d;
      rstS1_q <= resetPin_n;
      rstS2_q <= rstS1_q;
      rstS3_q <= rstS2_q;
      rstF_q  <= rstF_d;
    end
  end

  // bus: zero-wait slave, write data captured in the data phase
  always_comb begin
    wrPend_d  = 1'b0;
    addr_d    = addr_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    wakeIv_d  = wakeIv_q;
    wakeSrc_d = wakeSrc_q | (pinF_q & pinEn);
    tmrWake_d = tmrWake_q | tmrHit;
    if (wrPend_q) begin
      unique case (addr_q)
        `SPC_OFF_CTRL: ctrl_d = hwdata & 32'h0001_ff1f;
        `SPC_OFF_WAKE: wakeIv_d = hwdata[15:0];
        // write-one-to-clear; a fresh event in the same cycle still wins
        `SPC_OFF_STAT: begin
          wakeSrc_d = (wakeSrc_q & ~hwdata[7:0]) | (pinF_q & pinEn);
          tmrWake_d = (tmrWake_q & ~hwdata[8]) | tmrHit;
        end
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      wrPend_d = hwrite;
      addr_d   = {haddr[11:2], 2'b00};
      unique case ({haddr[11:2], 2'b00})
        `SPC_OFF_CTRL: rdata_d = ctrl_d;
        `SPC_OFF_WAKE: rdata_d = {16'h0000, wakeIv_d};
        `SPC_OFF_STAT: rdata_d = {19'h00000, 1'(st_q == spc_pkg::SPC_SLEEP), mode_q,
                                  tmrWake_d, wakeSrc_d};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_q  <= 1'b0;
      addr_q    <= 12'h000;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= `SPC_CTRL_RST;
      wakeIv_q  <= `SPC_WAKE_RST;
      wakeSrc_q <= 8'h00;
      tmrWake_q <= 1'b0;
    end else begin
      wrPend_q  <= wrPend_d;
      addr_q    <= addr_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      wakeIv_q  <= wakeIv_d;
      wakeSrc_q <= wakeSrc_d;
      tmrWake_q <= tmrWake_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // sleep fsm, lf timer and clock gates
  always_comb begin
    st_d    = st_q;
    mode_d  = mode_q;
    wake_d  = 1'b0;
    lfDiv_d = lfOn ? (lfTick ? 12'h000 : lfDiv_q + 12'h001) : 12'h000;
    tmr_d   = tmrHit ? 16'h0000 : (lfTick ? tmr_q + 16'h0001 : tmr_q);
    unique case (st_q)
      spc_pkg::SPC_RUN: begin
        if (sleepInstr && armed &&
            modeValid(ctrl_q[`SPC_CTRL_SEL_HI:`SPC_CTRL_SEL_LO])) begin // R1 R9
          st_d   = spc_pkg::SPC_SLEEP;
          mode_d = spc_pkg::spc_mode_t'(ctrl_q[`SPC_CTRL_SEL_HI:`SPC_CTRL_SEL_LO]); // R2
        end
      end
      spc_pkg::SPC_SLEEP: begin
        if (pinHit || tmrHit) begin // R3 R4 R9
          st_d = spc_pkg::SPC_WAKE;
        end
      end
      spc_pkg::SPC_WAKE: begin
        st_d   = spc_pkg::SPC_RUN;
        wake_d = 1'b1;
      end
      default: st_d = spc_pkg::SPC_RUN;
    endcase
    slp_d = (st_d == spc_pkg::SPC_SLEEP);
    gates_d.cpuClkEn   = !slp_d; // R9
    gates_d.ioClkEn    = !slp_d || mode_d == spc_pkg::SPC_IDLE;
    gates_d.adcClkEn   = !slp_d || mode_d == spc_pkg::SPC_IDLE ||
                         mode_d == spc_pkg::SPC_ADCNR;
    gates_d.lfOscEn    = ctrl_d[`SPC_CTRL_TMREN] &&
                         (!slp_d || lfRuns(mode_d, 1'b1));
    gates_d.mainOscEn  = !slp_d || mode_d == spc_pkg::SPC_IDLE ||
                         mode_d == spc_pkg::SPC_ADCNR || mode_d == spc_pkg::SPC_STBY ||
                         mode_d == spc_pkg::SPC_XSTBY;
    gates_d.radioPwrEn = !ctrl_d[`SPC_CTRL_RADIO]; // R6
    xr_d = !rstF_d; // R8
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q      <= spc_pkg::SPC_RUN;
      mode_q    <= spc_pkg::SPC_IDLE;
      lfDiv_q   <= 12'h000;
      tmr_q     <= 16'h0000;
      gates     <= `SPC_GATES_RST;
      sleeping  <= 1'b0;
      wakeEvent <= 1'b0;
      extReset  <= 1'b0;
    end else begin
      st_q      <= st_d;
      mode_q    <= mode_d;
      lfDiv_q   <= lfDiv_d;
      tmr_q     <= tmr_d;
      gates     <= gates_d;
      sleeping  <= slp_d;
      wakeEvent <= wake_d;
      extReset  <= xr_d;
    end
  end

  unarmed_no_sleep_a: assert property (@(posedge clk) disable iff (rst) // R1
    (st_q == spc_pkg::SPC_RUN && !armed) |=> st_q == spc_pkg::SPC_RUN)
    else $error("entered sleep while unarmed");
  mode_latched_a: assert property (@(posedge clk) disable iff (rst) // R2
    (st_q == spc_pkg::SPC_RUN && st_d == spc_pkg::SPC_SLEEP) |=>
      3'(mode_q) == $past(ctrl_q[`SPC_CTRL_SEL_HI:`SPC_CTRL_SEL_LO]))
    else $error("sleep mode not taken from selector");
  pin_wake_a: assert property (@(posedge clk) disable iff (rst) // R3
    (st_q == spc_pkg::SPC_SLEEP && pinHit) |=> st_q == spc_pkg::SPC_WAKE ##1 wakeEvent)
    else $error("pin did not wake device");
  timer_wake_a: assert property (@(posedge clk) disable iff (rst) // R4
    (st_q == spc_pkg::SPC_SLEEP && tmrHit) |=> st_q == spc_pkg::SPC_WAKE)
    else $error("timer did not wake device");
  variant_idle_a: assert property (@(posedge clk) disable iff (rst) // R5
    (st_q == spc_pkg::SPC_SLEEP && mode_q == spc_pkg::SPC_IDLE) |->
      lfOn == (LF_IDLE_OK && ctrl_q[`SPC_CTRL_TMREN]))
    else $error("lf timer in idle does not follow the variant option");
  radio_off_a: assert property (@(posedge clk) disable iff (rst) // R6
    ctrl_q[`SPC_CTRL_RADIO] |-> !gates.radioPwrEn)
    else $error("radio not powered off");
  clocks_back_a: assert property (@(posedge clk) disable iff (rst) // R9
    wakeEvent |-> gates.cpuClkEn && !sleeping)
    else $error("clocks not restored on wake");
  reset_pin_a: assert property (@(posedge clk) disable iff (rst) // R8
    (!rstS2_q && !rstS3_q) [*2] |=> extReset)
    else $error("low reset pin not seen");
endmodule

// file: sim/spc_wake_model.sv
// far-side model: pin interrupt sources and the external reset circuit
// assumes the bench requests pin levels and reset pulses on its own clock
`timescale 1ns/1ps
module spc_wake_model (
  // requests from the bench
  input  wire logic [7:0] pinReq,
  input  wire logic       rstReq,
  // pins into the controller
  output logic      [7:0] wakePins,
  output logic            resetPin_n
);
  // pin sources are plain levels, async to the controller clock
  assign wakePins = pinReq;
  // external reset circuit pulls low on request, pull-up holds it high otherwise
  assign resetPin_n = rstReq ? 1'b0 : 1'b1;
endmodule

// file: sim/spc_sleep_ctrl_tb.sv
// self-checking bench for the sleep controller
// assumes one 125 MHz clock, zero-wait AHB-Lite slave, wake model beside it
`timescale 1ns/1ps
module spc_sleep_ctrl_tb;
  typedef struct packed {logic arm; logic [2:0] mode; logic slp;} spc_row_t;
  logic               clk, rst, hsel, hwrite, sleepInstr, rstReq;
  logic [11:0]        haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata, hrdata, rd;
  logic               hreadyout, hresp, sleeping, wakeEvent, extReset, resetPin_n;
  logic [7:0]         pinReq, wakePins;
  spc_pkg::spc_gate_t gates;
  int                 error_cnt, n_compared;
  // disarmed, the six legal modes, then the two illegal codes
  spc_row_t rows [9] = '{5'h00, 5'h11, 5'h13, 5'h15, 5'h17, 5'h1d, 5'h1f, 5'h18, 5'h1a};
  // idle and power-save both keep the slow timer running on this variant
  logic [2:0] tmrModes [2] = '{3'h0, 3'h3};

  spc_sleep_ctrl u_spc_sleep_ctrl (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleepInstr(sleepInstr), .wakePins(wakePins),
    .resetPin_n(resetPin_n), .gates(gates), .sleeping(sleeping), .wakeEvent(wakeEvent),
    .extReset(extReset));
  spc_wake_model u_spc_wake_model (
    .pinReq(pinReq), .rstReq(rstReq), .wakePins(wakePins), .resetPin_n(resetPin_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out;
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chkBit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chkWord(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // bounded wait for hready, a hung bus counts as a mismatch
  task automatic rdyWait;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      close_out;
    end
  endtask

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    rdyWait;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdyWait;
    rd = hrdata;
    chkBit(hresp, 1'b0);
  endtask

  task automatic waitWake(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (wakeEvent === 1'b1) return;
    end
    error_cnt++;
    close_out;
  endtask

  task automatic doSleep;
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    {rst, hsel, hwrite, sleepInstr, rstReq} = 5'h10;
    {haddr, htrans, hsize, hwdata, pinReq} = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    #1 chkWord({26'h0, gates}, 32'h3f);
    chkWord({29'h0, sleeping, wakeEvent, extReset}, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    // timer enable is off out of reset, so the slow oscillator gate drops
    #1 chkWord({26'h0, gates}, 32'h3b);
    ahb(1'b0, 12'h000, 32'h0);
    chkWord(rd, 32'h0);
    ahb(1'b0, 12'h008, 32'h0);
    chkWord(rd, 32'h20);
    // reserved word ignores writes and reads zero
    ahb(1'b1, 12'h004, 32'hffff_ffff);
    ahb(1'b0, 12'h004, 32'h0);
    chkWord(rd, 32'h0);
    ahb(1'b1, 12'h000, 32'h10);
    #1 chkBit(gates.radioPwrEn, 1'b0);
    foreach (rows[k]) begin
      ahb(1'b1, 12'h000, {16'h0, 8'h01, 4'h0, rows[k].mode, rows[k].arm});
      doSleep;
      chkBit(sleeping, rows[k].slp);
      if (rows[k].slp) begin
        chkBit(gates.cpuClkEn, 1'b0);
        ahb(1'b0, 12'h00c, 32'h0);
        chkWord({28'h0, rd[12:9]}, {28'h0, 1'b1, rows[k].mode});
        pinReq <= 8'h01;
        waitWake(20);
        chkBit(sleeping, 1'b0);
        chkWord({26'h0, gates}, 32'h3b);
        pinReq <= 8'h00;
        // let the synchronised pin fall first, a live event would beat the clear
        repeat (6) @(posedge clk);
        ahb(1'b0, 12'h00c, 32'h0);
        chkBit(rd[0], 1'b1);
        ahb(1'b1, 12'h00c, 32'h1ff);
        ahb(1'b0, 12'h00c, 32'h0);
        chkWord(rd & 32'h1ff, 32'h0);
      end
    end
    // pins masked: only the slow timer can end the sleep
    ahb(1'b1, 12'h008, 32'h1);
    foreach (tmrModes[m]) begin
      ahb(1'b1, 12'h00c, 32'h1ff);
      ahb(1'b1, 12'h000, {15'h0, 1'b1, 12'h0, tmrModes[m], 1'b1});
      doSleep;
      chkBit(sleeping, 1'b1);
      waitWake(10000);
      chkBit(sleeping, 1'b0);
      ahb(1'b0, 12'h00c, 32'h0);
      chkBit(rd[8], 1'b1);
    end
    rstReq <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chkBit(extReset, 1'b1);
    rstReq <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chkBit(extReset, 1'b0);
    close_out;
  end
endmodule
